// ==== cms_cycle_measure.sv ====
// cycle measurement timer with external event stall detection and limit stop
`timescale 1ns/1ps
// Behaviour
// - a sticky timer overflow flag in the status register lets software judge whether the event input has stopped.
// - a counter wrap after measurement starts and before the first qualifying edge sets the overflow flag.
// - the first qualifying edge is rising or falling as the edge polarity select bit chooses.
// - with stop on limit enabled, measurement halts in the same cycle any of the four limit flags is set.
// - software clears the limit flag that caused the halt, and measurement then restarts.
// - after a restart a wrap before the first qualifying edge sets the overflow flag again.
module cms_cycle_measure
  import cms_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic event_input_pin,
  input wire logic [cms_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [cms_pkg::DATA_W-1:0] wdata,
  input wire logic [cms_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cms_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [cms_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  import cms_pkg::*;

  // limit check: bit1 = above max, bit0 = below min
  function automatic logic [1:0] limit_check(input logic [CNT_W-1:0] value, input logic [CNT_W-1:0] max_v,
                                             input logic [CNT_W-1:0] min_v);
    limit_check = {value > max_v, value < min_v};
  endfunction : limit_check

  // byte-lane merge of a 16-bit field, upper lanes have no storage
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v, input logic [DATA_W-1:0] data,
                                               input logic [STRB_W-1:0] strb);
    merge16 = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
  endfunction : merge16

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;
  logic wr_err;

  cms_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // software state
  logic [CTRL_W-1:0] cycle_measure_control_reg;
  logic [NUM_FLAGS-1:0] status;
  logic [NUM_FLAGS-1:0] irq_enable;
  logic [CNT_W-1:0] width_max;
  logic [CNT_W-1:0] width_min;
  logic [CNT_W-1:0] period_max;
  logic [CNT_W-1:0] period_min;

  // measurement state
  cms_state_t state;
  cms_state_t next_state;
  logic [CNT_W-1:0] timer_count;
  logic [CNT_W-1:0] next_timer_count;
  logic [CNT_W-1:0] width_capt;
  logic [CNT_W-1:0] period_capt;
  logic [NUM_LIMITS-1:0] halt_cause;
  logic event_prev;

  // write decode
  wire wr_ctrl = wr_en && (wr_addr == OFS_CTRL);
  wire wr_clear = wr_en && (wr_addr == OFS_CLEAR);
  wire wr_irq_en = wr_en && (wr_addr == OFS_IRQ_EN);
  wire wr_wmax = wr_en && (wr_addr == OFS_WIDTH_MAX);
  wire wr_wmin = wr_en && (wr_addr == OFS_WIDTH_MIN);
  wire wr_pmax = wr_en && (wr_addr == OFS_PERIOD_MAX);
  wire wr_pmin = wr_en && (wr_addr == OFS_PERIOD_MIN);
  wire wr_ro = wr_en && (wr_addr == OFS_STATUS || wr_addr == OFS_WIDTH_CAPT ||
                         wr_addr == OFS_PERIOD_CAPT || wr_addr == OFS_STATE);
  // read-only registers ignore writes but answer okay; unmapped gets slverr
  assign wr_err = !(wr_ctrl || wr_clear || wr_irq_en || wr_wmax || wr_wmin || wr_pmax || wr_pmin || wr_ro);

  wire measure_enable = cycle_measure_control_reg[CTRL_MEASURE_EN];
  wire edge_polarity_select = cycle_measure_control_reg[CTRL_EDGE_POL];
  wire stop_on_limit_enable = cycle_measure_control_reg[CTRL_STOP_EN];

  // edge detection; the pin is taken as synchronous to aclk
  wire event_rise = event_input_pin && !event_prev;
  wire event_fall = !event_input_pin && event_prev;
  wire active_edge = edge_polarity_select ? event_fall : event_rise;
  wire closing_edge = edge_polarity_select ? event_rise : event_fall;

  wire in_wait = (state == CMS_WAIT_FIRST);
  wire in_measure = (state == CMS_MEASURE);
  wire in_halt = (state == CMS_HALT);
  wire counter_wrap = (timer_count == CNT_FULL);

  // the first edge wins over a wrap in the same cycle
  wire ovf_event = measure_enable && in_wait && counter_wrap && !active_edge;
  wire width_done = measure_enable && in_measure && closing_edge;
  wire period_done = measure_enable && in_measure && active_edge;
  wire [1:0] width_chk = limit_check(timer_count, width_max, width_min);
  wire [1:0] period_chk = limit_check(timer_count, period_max, period_min);

  wire [NUM_LIMITS-1:0] limit_set = {period_done && period_chk[0], period_done && period_chk[1],
                                     width_done && width_chk[0], width_done && width_chk[1]};
  wire [NUM_FLAGS-1:0] flag_set = {limit_set, ovf_event};
  wire [NUM_FLAGS-1:0] flag_clr = wr_clear ? wr_data[NUM_FLAGS-1:0] : FLAGS_RESET;
  wire [NUM_FLAGS-1:0] next_status = (status & ~flag_clr) | flag_set;
  wire [NUM_LIMITS-1:0] limit_flags = status[NUM_FLAGS-1:FLAG_LIM_LO];
  wire halt_now = stop_on_limit_enable && (limit_set != LIMITS_NONE);
  wire cause_cleared = ((limit_flags & halt_cause) == LIMITS_NONE);

  always_comb
  begin
    next_state = state;
    next_timer_count = timer_count;
    if (!measure_enable)
    begin
      next_state = CMS_IDLE;
      next_timer_count = CNT_ZERO;
    end
    else
    begin
      unique case (state)
        CMS_IDLE:
        begin
          next_state = CMS_WAIT_FIRST;
          next_timer_count = CNT_ZERO;
        end
        CMS_WAIT_FIRST:
        begin
          if (active_edge)
          begin
            next_state = CMS_MEASURE;
            next_timer_count = CNT_ONE;
          end
          else
            next_timer_count = timer_count + CNT_ONE; // wraps on purpose
        end
        CMS_MEASURE:
        begin
          if (halt_now)
          begin
            next_state = CMS_HALT;
            next_timer_count = CNT_ZERO;
          end
          else if (period_done)
            next_timer_count = CNT_ONE;
          else if (!counter_wrap)
            next_timer_count = timer_count + CNT_ONE; // saturates so a long gap reads as max
        end
        CMS_HALT:
        begin
          if (cause_cleared)
          begin
            next_state = CMS_WAIT_FIRST;
            next_timer_count = CNT_ZERO;
          end
        end
        default:
        begin
          next_state = CMS_IDLE;
          next_timer_count = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= CMS_IDLE;
      timer_count <= CNT_ZERO;
      event_prev <= 1'b0;
      halt_cause <= LIMITS_NONE;
    end
    else
    begin
      state <= next_state;
      timer_count <= next_timer_count;
      event_prev <= event_input_pin;
      if (in_measure && halt_now)
        halt_cause <= limit_set; // remembers which flag must be cleared
      else if (!in_halt)
        halt_cause <= LIMITS_NONE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      width_capt <= CNT_ZERO;
      period_capt <= CNT_ZERO;
    end
    else
    begin
      if (width_done)
        width_capt <= timer_count;
      if (period_done)
        period_capt <= timer_count;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= FLAGS_RESET;
    else
      status <= next_status; // set beats a clear in the same cycle
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cycle_measure_control_reg <= CTRL_RESET;
      irq_enable <= FLAGS_RESET;
      width_max <= MAX_RESET;
      width_min <= MIN_RESET;
      period_max <= MAX_RESET;
      period_min <= MIN_RESET;
    end
    else
    begin
      if (wr_ctrl && wr_strb[0])
        cycle_measure_control_reg <= wr_data[CTRL_W-1:0];
      if (wr_irq_en && wr_strb[0])
        irq_enable <= wr_data[NUM_FLAGS-1:0];
      if (wr_wmax)
        width_max <= merge16(width_max, wr_data, wr_strb);
      if (wr_wmin)
        width_min <= merge16(width_min, wr_data, wr_strb);
      if (wr_pmax)
        period_max <= merge16(period_max, wr_data, wr_strb);
      if (wr_pmin)
        period_min <= merge16(period_min, wr_data, wr_strb);
    end
  end

  // level interrupt from the registered status, so it follows the flag
  assign irq = |(status & irq_enable);

  // read decode
  wire [DATA_W-1:0] state_word = {timer_count, {(DATA_W - CNT_W - 4){1'b0}}, state};
  assign rd_err = !(rd_addr == OFS_CTRL || rd_addr == OFS_STATUS || rd_addr == OFS_CLEAR ||
                    rd_addr == OFS_IRQ_EN || rd_addr == OFS_WIDTH_MAX || rd_addr == OFS_WIDTH_MIN ||
                    rd_addr == OFS_PERIOD_MAX || rd_addr == OFS_PERIOD_MIN || rd_addr == OFS_WIDTH_CAPT ||
                    rd_addr == OFS_PERIOD_CAPT || rd_addr == OFS_STATE);
  assign rd_data =
    (rd_addr == OFS_CTRL) ? {{(DATA_W - CTRL_W){1'b0}}, cycle_measure_control_reg} :
    (rd_addr == OFS_STATUS) ? {{(DATA_W - NUM_FLAGS){1'b0}}, status} :
    (rd_addr == OFS_IRQ_EN) ? {{(DATA_W - NUM_FLAGS){1'b0}}, irq_enable} :
    (rd_addr == OFS_WIDTH_MAX) ? {{(DATA_W - CNT_W){1'b0}}, width_max} :
    (rd_addr == OFS_WIDTH_MIN) ? {{(DATA_W - CNT_W){1'b0}}, width_min} :
    (rd_addr == OFS_PERIOD_MAX) ? {{(DATA_W - CNT_W){1'b0}}, period_max} :
    (rd_addr == OFS_PERIOD_MIN) ? {{(DATA_W - CNT_W){1'b0}}, period_min} :
    (rd_addr == OFS_WIDTH_CAPT) ? {{(DATA_W - CNT_W){1'b0}}, width_capt} :
    (rd_addr == OFS_PERIOD_CAPT) ? {{(DATA_W - CNT_W){1'b0}}, period_capt} :
    (rd_addr == OFS_STATE) ? state_word :
    {DATA_W{1'b0}};
endmodule : cms_cycle_measure

// ==== cms_pkg.sv ====
// constants, register map and types for the cycle measurement stall detector
package cms_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int CNT_W = 16;
  localparam int NUM_FLAGS = 5;
  localparam int NUM_LIMITS = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WIDTH_MAX = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WIDTH_MIN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_MAX = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_MIN = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_WIDTH_CAPT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_CAPT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h28;

  // control register fields
  localparam int CTRL_MEASURE_EN = 0;
  localparam int CTRL_EDGE_POL = 1;
  localparam int CTRL_STOP_EN = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // status / clear / irq enable fields
  localparam int FLAG_OVF = 0;
  localparam int FLAG_WMX = 1;
  localparam int FLAG_WMN = 2;
  localparam int FLAG_PMX = 3;
  localparam int FLAG_PMN = 4;
  localparam int FLAG_LIM_LO = 1;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h00;
  localparam logic [NUM_LIMITS-1:0] LIMITS_NONE = 4'h0;

  // state register fields
  localparam int STATE_COUNT_LO = 16;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
  localparam logic [CNT_W-1:0] MAX_RESET = 16'hffff;
  localparam logic [CNT_W-1:0] MIN_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CMS_IDLE = 4'h1,
    CMS_WAIT_FIRST = 4'h2,
    CMS_MEASURE = 4'h4,
    CMS_HALT = 4'h8
  } cms_state_t;
endpackage : cms_pkg

// ==== cms_axil_slave.sv ====
// axi4-lite slave front end: turns channel handshakes into register strobes
`timescale 1ns/1ps
module cms_axil_slave
  import cms_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cms_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [cms_pkg::DATA_W-1:0] wdata,
  input wire logic [cms_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [cms_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [cms_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [cms_pkg::ADDR_W-1:0] wr_addr,
  output logic [cms_pkg::DATA_W-1:0] wr_data,
  output logic [cms_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [cms_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [cms_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_err
);
  logic aw_held;
  logic w_held;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;

  // address and data are taken independently, in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_en = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule : cms_axil_slave

// ==== cms_event_src.sv ====
// event source model: drives two pulses on the event input when asked
`timescale 1ns/1ps
module cms_event_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  output logic pin,
  output logic busy
);
  // pin rests low between bursts, as the edge detector expects
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (2)
        begin
          pin <= 1'b1;
          repeat (hi) @(posedge aclk);
          pin <= 1'b0;
          repeat (lo) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : cms_event_src

// ==== cms_cycle_measure_chk.sv ====
// port-level checks on bus handshakes and the interrupt line
`timescale 1ns/1ps
module cms_cycle_measure_chk
  import cms_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [cms_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [cms_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_reset_idle: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq)
    else $error("outputs busy after reset");
  chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  chk_b_latency: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after take");
  chk_r_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  chk_ar_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  chk_w_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_unmapped_err: assert property (arvalid && arready && araddr > OFS_STATE |=> rresp == RESP_SLVERR && rdata == '0)
    else $error("unmapped read not refused");
  // only a software write may lower the interrupt
  chk_irq_sticky: assert property ($fell(irq) |-> $past(wvalid && wready, 2))
    else $error("interrupt fell without a write");
  cover property (bvalid && bready && bresp == RESP_SLVERR);
  cover property (rvalid && rready && rresp == RESP_SLVERR);
  cover property ($rose(irq));
endmodule : cms_cycle_measure_chk
bind cms_cycle_measure cms_cycle_measure_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);

// ==== cms_cycle_measure_tb.sv ====
// self-checking bench for the cycle measurement stall detector
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cms_cycle_measure_tb;
  import cms_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cms_note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, hi = 8'h1, lo = 8'h1;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, event_input_pin, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h1e2b;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  cms_note_t nt;
  logic [1:0] br;
  cms_note_t rq[$];
  logic [1:0] bq[$];
  logic [7:0] lim_ofs[1:4] = '{OFS_WIDTH_MAX, OFS_WIDTH_MIN, OFS_PERIOD_MAX, OFS_PERIOD_MIN};
  logic [31:0] lim_val[1:4] = '{32'h3, 32'h28, 32'ha, 32'h64};
  logic [31:0] lim_def[1:4] = '{32'hffff, 32'h0, 32'hffff, 32'h0};
  always #25 aclk = ~aclk;
  cms_cycle_measure u_cms_cycle_measure (.aclk, .aresetn, .event_input_pin, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq);
  cms_event_src u_cms_event_src (.aclk, .go, .hi, .lo, .pin(event_input_pin), .busy);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back('{d, m, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
  endtask : rd
  task automatic start(input logic [7:0] h, input logic [7:0] l);
    hi <= h;
    lo <= l;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
  endtask : start
  task automatic settle();
    while (busy) @(posedge aclk);
  endtask : settle
  // answers are compared in arrival order against the notes queued by the driver
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      nt = rq.pop_front();
      `CHK(rdata & nt.m, nt.d)
      `CHK(rresp, nt.r)
    end
    // pop once: the compare macro evaluates its expected value twice
    if (bvalid && bready)
    begin
      br = bq.pop_front();
      `CHK(bresp, br)
    end
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_IRQ_EN, 32'h0);
    rd(OFS_WIDTH_MAX, 32'hffff);
    rd(OFS_STATE, 32'h1, 32'hf);
    rd(8'h40, 32'h0, '1, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFS_STATUS, 32'h1f);
    rd(OFS_STATUS, 32'h0);
    $display("reset test done");
    wr(OFS_CTRL, 32'h3);
    start(8'h28, 8'h28);
    repeat (8) @(posedge aclk);
    rd(OFS_STATE, 32'h2, 32'hf);
    repeat (40) @(posedge aclk);
    rd(OFS_STATE, 32'h4, 32'hf);
    settle();
    // falling polarity: width spans the low phase, period one full pulse
    rd(OFS_WIDTH_CAPT, 32'(lo));
    rd(OFS_PERIOD_CAPT, 32'(hi) + 32'(lo));
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATE, 32'h1, 32'hf);
    $display("polarity test done");
    for (int k = 1; k <= 4; k++)
    begin
      wr(OFS_CTRL, 32'h0);
      wr(lim_ofs[k], lim_val[k]);
      wr(OFS_CTRL, 32'h5);
      rd(OFS_STATE, 32'h2, 32'hf);
      start(8'(32'h8 + (rnd() & 32'h7)), 8'(32'h8 + (rnd() & 32'h7)));
      settle();
      rd(OFS_STATUS, 32'h1 << k);
      rd(OFS_STATE, 32'h8, 32'hf);
      wr(OFS_IRQ_EN, 32'h1f ^ (32'h1 << k));
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_EN, 32'h1 << k);
      `CHK(irq, 1'b1)
      rd(OFS_STATUS, 32'h1 << k);
      wr(OFS_CLEAR, 32'h1 << k);
      `CHK(irq, 1'b0)
      rd(OFS_STATUS, 32'h0);
      rd(OFS_STATE, 32'h2, 32'hf);
      wr(OFS_IRQ_EN, 32'h0);
      wr(lim_ofs[k], lim_def[k]);
    end
    $display("limit test done");
    // measurement restarted above with the pin quiet; wrap is due 65536 cycles on
    wr(OFS_IRQ_EN, 32'h1);
    repeat (65400) @(posedge aclk);
    rd(OFS_STATUS, 32'h0);
    repeat (150) @(posedge aclk);
    rd(OFS_STATUS, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_STATUS, 32'h0);
    $display("stall test done");
    summarize();
  end
endmodule : cms_cycle_measure_tb
